// ==== term_ctl_pkg.sv ====
// shared constants, field layouts and carrier types for terminal run control
`default_nettype none
package term_ctl_pkg;

  // clock rate and time figures
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          DECEL_TIME_MS  = 15000;   // ramp-down time after reset
  localparam logic [31:0] DECEL_RESET_CYC =
    32'(DECEL_TIME_MS * (CLK_HZ / 1000));

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_DECEL     = 8'h04;
  localparam logic [7:0]  ADDR_CMD       = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0c;

  // control register fields
  localparam int          CTRL_SRC_LSB   = 0;       // command_source_sel
  localparam int          CTRL_MODE_LSB  = 2;       // terminal_control_mode_sel
  localparam int          CTRL_INHIBIT   = 4;       // reverse_inhibit
  localparam int          CTRL_STOP_MODE = 5;       // stop_mode_sel
  localparam int          CTRL_THREE_FN  = 6;       // input_terminal_function_cfg
  localparam int          CTRL_W         = 7;
  localparam logic [6:0]  CTRL_RESET     = 7'h00;
  localparam int          CMD_EXT_STOP   = 0;

  // field encodings
  localparam logic [1:0]  SRC_TERMINAL   = 2'h1;
  localparam logic [1:0]  MODE_2L_LEVEL  = 2'h0;
  localparam logic [1:0]  MODE_2L_SPLIT  = 2'h1;
  localparam logic [1:0]  MODE_3L_SPLIT  = 2'h2;
  localparam logic [1:0]  MODE_3L_DIR    = 2'h3;
  localparam logic        STOP_FREE      = 1'b1;

  localparam int          TERM_W         = 4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FWD   = 4'b0010,
    ST_REV   = 4'b0100,
    ST_DECEL = 4'b1000
  } state_t;

  typedef struct packed {
    logic stop_key;    // panel stop key
    logic stop_term;   // stop_input_terminal
    logic dir;         // direction terminal
    logic run;         // run terminal
  } term_pins_t;

  typedef struct packed {
    logic [1:0]  src;
    logic [1:0]  mode;
    logic        inhibit;
    logic        stop_mode;
    logic        three_fn;
    logic [31:0] decel_cyc;
  } cfg_t;

  typedef struct packed {
    logic rearm_wait;
    logic coast;
    logic decel;
    logic reverse;
    logic run;
  } status_t;

  // two-line modes are 0 and 1
  function automatic logic is_two_line(input logic [1:0] mode);
    return (mode == MODE_2L_LEVEL) || (mode == MODE_2L_SPLIT);
  endfunction : is_two_line

endpackage : term_ctl_pkg
`default_nettype wire

// ==== term_sync.sv ====
// two-stage synchroniser for the terminal inputs
`default_nettype none
module term_sync
  import term_ctl_pkg::*;
(
  input  wire logic       pclk,        // system clock
  input  wire logic       presetn,     // async reset, active low
  input  wire logic       ce,          // clock enable
  input  wire term_pins_t pins_async,  // raw terminal levels
  output var  term_pins_t pins_sync    // synchronised levels
);

  wire logic [TERM_W-1:0] raw;
  wire logic [TERM_W-1:0] stage2;

  assign raw       = pins_async;
  assign pins_sync = stage2;

  // one flop pair per terminal, each pair owns its own flops
  genvar i;
  generate
    for (i = 0; i < TERM_W; i++) begin : g_bit
      logic s1;
      logic s2;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else if (ce) begin
          s1 <= raw[i];
          s2 <= s1;
        end
      end
      assign stage2[i] = s2;
    end
  endgenerate

endmodule : term_sync
`default_nettype wire

// ==== term_apb_regs.sv ====
// apb slave holding control, ramp time, command and status registers
`default_nettype none
module term_apb_regs
  import term_ctl_pkg::*;
#(
  parameter logic [31:0] DECEL_RESET = DECEL_RESET_CYC
) (
  input  wire logic        pclk,      // system clock
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        ce,        // clock enable
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  input  wire status_t     status,    // block state to read back
  output logic [31:0]      prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // unmapped address
  output cfg_t             cfg,       // configuration to the core
  output logic             ext_stop   // one-cycle external stop
);

  logic [CTRL_W-1:0] ctrl;
  logic [31:0]       decel;
  logic [31:0]       next_rdata;

  // address decode and transfer phases
  wire access    = psel & penable;
  wire first_acc = access & ~pready;
  wire wr_take   = access & pready & pwrite;
  wire hit_ctrl  = paddr == ADDR_CTRL;
  wire hit_decel = paddr == ADDR_DECEL;
  wire hit_cmd   = paddr == ADDR_CMD;
  wire hit_stat  = paddr == ADDR_STATUS;
  wire mapped    = hit_ctrl | hit_decel | hit_cmd | hit_stat;

  // read mux, unused bits read as zero
  assign next_rdata = hit_ctrl  ? {25'h0, ctrl} :
                      hit_decel ? decel :
                      hit_stat  ? {27'h0, status} : 32'h0;

  // configuration fields
  assign cfg.src       = ctrl[CTRL_SRC_LSB +: 2];
  assign cfg.mode      = ctrl[CTRL_MODE_LSB +: 2];
  assign cfg.inhibit   = ctrl[CTRL_INHIBIT];
  assign cfg.stop_mode = ctrl[CTRL_STOP_MODE];
  assign cfg.three_fn  = ctrl[CTRL_THREE_FN];
  assign cfg.decel_cyc = decel;

  // one wait state, writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      ctrl     <= CTRL_RESET;
      decel    <= DECEL_RESET;
      ext_stop <= 1'b0;
    end else if (ce) begin
      pready   <= first_acc;
      ext_stop <= wr_take & hit_cmd & pwdata[CMD_EXT_STOP];
      if (first_acc) begin
        prdata  <= pwrite ? 32'h0 : next_rdata;
        pslverr <= ~mapped;
      end
      if (wr_take & hit_ctrl) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (wr_take & hit_decel) begin
        decel <= pwdata;
      end
    end
  end

endmodule : term_apb_regs
`default_nettype wire

// ==== term_run_ctl.sv ====
// terminal run, stop and direction command decoder
//
// How it works
// [R1] mode 0: run terminal level, direction selects reverse
// [R2] reverse inhibit set: direction terminal ignored outside mode 1
// [R3] mode 1: run forward, direction reverse, release stops
// [R4] mode 1: both terminals active means stop
// [R5] mode 1 inhibit: reverse terminal never starts drive
// [R6] stop key halts; rerun needs terminal cycled
// [R7] mode 2: edges start forward or reverse
// [R8] mode 2: stop contact normally closed, opening stops
// [R9] mode 3: run edge starts, direction level chooses
// [R10] mode 3: stop input level halts running
// [R11] three-line stop only when function configured
// [R12] terminal commands apply only under terminal source
// [R13] stop mode 1 coasts, 0 ramps down
// [R14] terminals pass two flops before any use
// [R15] operator holds each contact level at least two clock cycles
`default_nettype none
module term_run_ctl
  import term_ctl_pkg::*;
#(
  parameter logic [31:0] DECEL_RESET = DECEL_RESET_CYC
) (
  input  wire logic        pclk,                // system clock, 40 MHz
  input  wire logic        presetn,             // async reset, active low
  input  wire logic        ce,                  // clock enable, freezes all
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic [31:0]      prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  input  wire logic        run_terminal,        // run input pin
  input  wire logic        direction_terminal,  // direction input pin
  input  wire logic        stop_input_terminal, // three-line stop pin
  input  wire logic        stop_key,            // panel stop key
  output logic             drive_run,           // drive running
  output logic             drive_reverse,       // direction is reverse
  output logic             drive_decel,         // ramping down
  output logic             drive_coast          // output cut, coasting
);

  term_pins_t pins_raw;
  term_pins_t pins;
  cfg_t       cfg;
  status_t    status;
  state_t     state;
  state_t     next_state;
  logic       ext_stop;
  logic       run_d;
  logic       dir_d;
  logic       rearm_wait;
  logic [31:0] decel_cnt;

  assign pins_raw.stop_key  = stop_key;
  assign pins_raw.stop_term = stop_input_terminal;
  assign pins_raw.dir       = direction_terminal;
  assign pins_raw.run       = run_terminal;

  // [R14] two-flop synchroniser
  term_sync u_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .pins_async (pins_raw),
    .pins_sync  (pins)
  );

  term_apb_regs #(
    .DECEL_RESET (DECEL_RESET)
  ) u_regs (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .status   (status),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .cfg      (cfg),
    .ext_stop (ext_stop)
  );

  assign status.rearm_wait = rearm_wait;
  assign status.coast      = drive_coast;
  assign status.decel      = drive_decel;
  assign status.reverse    = drive_reverse;
  assign status.run        = drive_run;

  // [R14] edge detect on synchronised levels, one event per edge
  wire run_rise = pins.run & ~run_d;
  wire dir_rise = pins.dir & ~dir_d;

  // mode and setting decode
  wire two_line  = is_two_line(cfg.mode);
  wire mode0     = cfg.mode == MODE_2L_LEVEL;
  wire mode1     = cfg.mode == MODE_2L_SPLIT;
  wire mode2     = cfg.mode == MODE_3L_SPLIT;
  wire rev_ok    = ~cfg.inhibit;
  wire running   = (state == ST_FWD) | (state == ST_REV);
  // [R12] terminal source gate
  wire from_term = cfg.src == SRC_TERMINAL;
  wire user_stop = pins.stop_key | ext_stop;

  // [R11] three-line stop honoured only when configured
  // [R8] mode 2 contact normally closed, [R10] mode 3 active level
  wire stop_level = cfg.three_fn & ~two_line &
                    (mode2 ? ~pins.stop_term : pins.stop_term);

  // [R1] [R2] mode 0 levels; [R3] [R4] [R5] mode 1 levels
  wire lvl_fwd = mode0 ? pins.run & ~(pins.dir & rev_ok)
                       : pins.run & ~pins.dir;
  wire lvl_rev = mode0 ? pins.run & pins.dir & rev_ok
                       : pins.dir & ~pins.run & rev_ok;
  wire lvl_req = lvl_fwd | lvl_rev;
  wire both_on = mode1 & pins.run & pins.dir;
  wire cmd_idle = ~pins.run & ~(mode1 & pins.dir & rev_ok);

  // [R7] reverse edge start in mode 2 only
  wire edge_rev = mode2 & dir_rise & rev_ok;

  // start and stop requests
  wire go = from_term & ~user_stop &
            (two_line ? lvl_req & ~rearm_wait
                      : (run_rise | edge_rev) & ~stop_level);
  wire halt = ~from_term | user_stop |
              (two_line ? ~lvl_req | rearm_wait : stop_level);

  // [R9] mode 3 level direction; [R7] mode 2 latest edge
  wire want_rev = two_line ? lvl_rev :
                  mode2    ? (edge_rev | (~run_rise & state == ST_REV)) :
                             pins.dir & rev_ok;

  // next state decision
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (go) begin
          next_state = want_rev ? ST_REV : ST_FWD;
        end
      end
      ST_DECEL: begin
        if (go) begin
          next_state = want_rev ? ST_REV : ST_FWD;
        end else if (decel_cnt == 32'h0) begin
          next_state = ST_IDLE;
        end
      end
      ST_FWD, ST_REV: begin
        // [R13] free stop or ramp
        if (halt) begin
          next_state = (cfg.stop_mode == STOP_FREE) ? ST_IDLE : ST_DECEL;
        end else begin
          next_state = want_rev ? ST_REV : ST_FWD;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire next_run   = (next_state == ST_FWD) | (next_state == ST_REV);
  wire enter_dec  = running & (next_state == ST_DECEL);
  wire free_stop  = running & (next_state == ST_IDLE);

  // state, edge history and ramp counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      run_d     <= 1'b0;
      dir_d     <= 1'b0;
      decel_cnt <= 32'h0;
    end else if (ce) begin
      state <= next_state;
      run_d <= pins.run;
      dir_d <= pins.dir;
      // [R13] ramp-down length in cycles
      if (enter_dec) begin
        decel_cnt <= cfg.decel_cyc;
      end else if (state == ST_DECEL && decel_cnt != 32'h0) begin
        decel_cnt <= decel_cnt - 32'h1;
      end
    end
  end

  // [R6] stop lockout until the terminal is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rearm_wait <= 1'b0;
    end else if (ce) begin
      if (two_line & user_stop & ~cmd_idle) begin
        rearm_wait <= 1'b1;
      end else if (cmd_idle | ~two_line) begin
        rearm_wait <= 1'b0;
      end
    end
  end

  // registered drive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_run     <= 1'b0;
      drive_reverse <= 1'b0;
      drive_decel   <= 1'b0;
      drive_coast   <= 1'b0;
    end else if (ce) begin
      drive_run     <= next_run;
      drive_reverse <= (next_state == ST_REV) |
                       (next_state == ST_DECEL & drive_reverse);
      drive_decel   <= next_state == ST_DECEL;
      // [R13] coast holds until the next start
      drive_coast   <= free_stop | (drive_coast & ~next_run);
    end
  end

  // checks on the decoder
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mode0_level_run: assert property ( // [R1]
    ce && from_term && mode0 && state == ST_IDLE && pins.run &&
    !rearm_wait && !user_stop |=> drive_run)
    else $error("mode 0 run level did not start the drive");

  a_mode0_inhibit_dir: assert property ( // [R2]
    ce && mode0 && cfg.inhibit && state != ST_DECEL |=> !drive_reverse)
    else $error("mode 0 reversed while reverse inhibited");

  a_mode1_rev_start: assert property ( // [R3]
    ce && from_term && mode1 && state == ST_IDLE && pins.dir &&
    !pins.run && rev_ok && !rearm_wait && !user_stop
    |=> drive_run && drive_reverse)
    else $error("mode 1 reverse terminal did not start reverse");

  a_mode1_both_stop: assert property ( // [R4]
    ce && both_on && running |=> !drive_run)
    else $error("mode 1 kept running with both terminals active");

  a_mode1_no_reverse: assert property ( // [R5]
    ce && mode1 && cfg.inhibit && state == ST_IDLE |=> !drive_reverse)
    else $error("mode 1 started reverse while inhibited");

  a_stop_locks_out: assert property ( // [R6]
    ce && two_line && user_stop && !cmd_idle
    |=> rearm_wait && !drive_run)
    else $error("stop key did not lock out the run terminal");

  a_rearm_blocks: assert property ( // [R6]
    ce && rearm_wait && !cmd_idle |=> !drive_run)
    else $error("drive restarted without terminal cycling");

  a_edge_fwd_start: assert property ( // [R7]
    ce && from_term && mode2 && state == ST_IDLE && run_rise &&
    !dir_rise && !stop_level && !user_stop
    |=> drive_run && !drive_reverse)
    else $error("mode 2 run edge did not start forward");

  a_level_no_start: assert property ( // [R7]
    ce && !two_line && state == ST_IDLE && !run_rise && !dir_rise
    |=> !drive_run)
    else $error("three-line mode started on a steady level");

  a_mode3_dir_level: assert property ( // [R9]
    ce && cfg.mode == MODE_3L_DIR && running && !halt
    |=> drive_reverse == $past(pins.dir && rev_ok))
    else $error("mode 3 direction does not follow its terminal");

  a_three_line_stop: assert property ( // [R8]
    ce && !two_line && running && stop_level |=> !drive_run)
    else $error("three-line stop level did not halt running");

  a_stop_unconfigured: assert property ( // [R11]
    ce && !two_line && !cfg.three_fn && running && from_term &&
    !user_stop |=> drive_run)
    else $error("stop honoured without the three-line function");

  a_source_gate: assert property ( // [R12]
    ce && !from_term |=> !drive_run)
    else $error("terminal command applied under another source");

  a_free_coast: assert property ( // [R13]
    ce && running && halt && cfg.stop_mode == STOP_FREE
    |=> drive_coast && !drive_decel && !drive_run)
    else $error("free stop did not cut the output");

  a_ramp_decel: assert property ( // [R13]
    ce && running && halt && cfg.stop_mode != STOP_FREE
    |=> drive_decel ##0 decel_cnt == $past(cfg.decel_cyc))
    else $error("ramp stop did not load the ramp time");

  a_single_edge: assert property ( // [R14]
    ce && run_rise |=> !run_rise)
    else $error("one run edge gave more than one start");

  c_mode0_run: cover property (mode0 && ce && !running ##1 drive_run);
  c_mode2_rev: cover property (mode2 && ce && edge_rev ##1 drive_reverse);
  c_ramp_done: cover property (state == ST_DECEL ##1 state == ST_IDLE);
  c_coast:     cover property (ce && free_stop ##1 drive_coast);

endmodule : term_run_ctl
`default_nettype wire

// ==== op_panel.sv ====
// operator switches and pushbuttons wired to the terminal inputs
`default_nettype none
module op_panel
  import term_ctl_pkg::*;
(
  input  wire logic       pclk,     // system clock
  input  wire logic       presetn,  // async reset, active low
  input  wire logic       slow,     // operator reacts one edge late
  input  wire term_pins_t want,     // levels the bench asks for
  output var  term_pins_t pins      // levels seen at the terminals
);
  timeunit 1ns;
  timeprecision 1ps;

  term_pins_t late;       // delayed copy for a slow operator
  term_pins_t next_pins;  // level the contacts move to
  logic [1:0] held;       // edges since the last contact change

  // pick prompt or slow reaction
  assign next_pins = slow ? late : want;

  // contacts open at power-up; a change must stand before the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      late <= '0;
      held <= 2'h0;
    end else begin
      late <= want;
      if (held != 2'h3) held <= held + 2'h1;
      if (next_pins != pins && held >= 2'h1) begin
        pins <= next_pins;
        held <= 2'h0;
      end
    end
  end
endmodule : op_panel
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the terminal run command decoder
`default_nettype none
module tb_top
  import term_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DECEL = 20;  // short ramp for simulation

  logic        pclk, presetn, ce, psel, penable, pwrite, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, rd_err;
  logic        drive_run, drive_reverse, drive_decel, drive_coast;
  term_pins_t  want, pins;
  int          fail_count, checks;

  term_run_ctl #(.DECEL_RESET(32'(DECEL))) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_terminal(pins.run), .direction_terminal(pins.dir),
    .stop_input_terminal(pins.stop_term), .stop_key(pins.stop_key),
    .drive_run(drive_run), .drive_reverse(drive_reverse),
    .drive_decel(drive_decel), .drive_coast(drive_coast));

  op_panel panel_u (.pclk(pclk), .presetn(presetn), .slow(slow),
    .want(want), .pins(pins));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen,
               exp);
    end
  endtask : check

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) check(32'h0, 32'h1, "apb ready missing");
    rd_q   = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [31:0] ctl(input logic [1:0] mode,
    input logic inh, input logic smode, input logic tfn,
    input logic [1:0] src = SRC_TERMINAL);
    logic [31:0] w;
    w = '0;
    w[CTRL_SRC_LSB +: 2]  = src;
    w[CTRL_MODE_LSB +: 2] = mode;
    w[CTRL_INHIBIT]       = inh;
    w[CTRL_STOP_MODE]     = smode;
    w[CTRL_THREE_FN]      = tfn;
    return w;
  endfunction : ctl

  // set terminal levels {key, stop, dir, run} and let them propagate
  task automatic pin(input logic [3:0] v);
    want <= v;
    repeat (8) @(posedge pclk);
  endtask : pin

  // compare outputs {run, reverse, decel, coast} under a mask
  task automatic drv(input logic [3:0] e, input logic [3:0] m);
    check(32'({drive_run, drive_reverse, drive_decel, drive_coast} & m),
          32'(e), "drive outputs");
  endtask : drv

  task automatic idle();
    want <= '0;
    repeat (DECEL + 12) @(posedge pclk);
  endtask : idle

  // cut a hang short
  initial begin
    repeat (6000) @(posedge pclk);
    fail_count++;
    results();
  end

  // reset, then the test sequence
  initial begin
    fail_count = 0;
    checks = 0;
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd_q, 32'h0, "ctrl reset");
    apb(1'b0, ADDR_DECEL, 32'h0);
    check(rd_q, 32'(DECEL), "decel reset");
    apb(1'b0, 8'h10, 32'h0);
    check({rd_q[30:0], rd_err}, 32'h1, "unmapped access");
    $display("test registers done");
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_LEVEL, 0, 0, 0, 2'h0));
    pin(4'b0001);
    drv(4'b0000, 4'b1011);
    idle();
    $display("test source done");
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_LEVEL, 0, 0, 0));
    pin(4'b0001);
    drv(4'b1000, 4'b1111);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd_q, 32'h1, "status running");
    pin(4'b0011);
    drv(4'b1100, 4'b1111);
    pin(4'b0010);
    drv(4'b0110, 4'b1111);
    idle();
    drv(4'b0000, 4'b1011);
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_LEVEL, 1, 0, 0));
    pin(4'b0011);
    drv(4'b1000, 4'b1111);
    // clock enable low freezes the decoder while the pins move
    ce <= 1'b0;
    pin(4'b0000);
    drv(4'b1000, 4'b1111);
    ce <= 1'b1;
    idle();
    $display("test mode 0 done");
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_SPLIT, 0, 0, 0));
    pin(4'b0001);
    drv(4'b1000, 4'b1111);
    pin(4'b0011);
    drv(4'b0010, 4'b1011);
    idle();
    pin(4'b0010);
    drv(4'b1100, 4'b1111);
    pin(4'b0000);
    drv(4'b0010, 4'b1011);
    idle();
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_SPLIT, 1, 0, 0));
    pin(4'b0010);
    drv(4'b0000, 4'b1011);
    idle();
    $display("test mode 1 done");
    apb(1'b1, ADDR_CTRL, ctl(MODE_2L_LEVEL, 0, STOP_FREE, 0));
    pin(4'b0001);
    apb(1'b1, ADDR_CMD, 32'h1);
    pin(4'b0001);
    drv(4'b0001, 4'b1011);
    pin(4'b0000);
    pin(4'b0001);
    drv(4'b1000, 4'b1011);
    pin(4'b1001);
    drv(4'b0001, 4'b1011);
    pin(4'b0001);
    drv(4'b0001, 4'b1011);
    pin(4'b0000);
    pin(4'b0001);
    drv(4'b1000, 4'b1011);
    idle();
    $display("test stop and rearm done");
    apb(1'b1, ADDR_CTRL, ctl(MODE_3L_SPLIT, 0, 0, 1));
    pin(4'b0100);
    pin(4'b0101);
    pin(4'b0100);
    drv(4'b1000, 4'b1111);
    pin(4'b0110);
    pin(4'b0100);
    drv(4'b1100, 4'b1111);
    pin(4'b0000);
    drv(4'b0010, 4'b1011);
    idle();
    $display("test mode 2 done");
    slow <= 1'b1;
    apb(1'b1, ADDR_CTRL, ctl(MODE_3L_DIR, 0, STOP_FREE, 1));
    pin(4'b0001);
    pin(4'b0000);
    drv(4'b1000, 4'b1111);
    pin(4'b0010);
    drv(4'b1100, 4'b1111);
    pin(4'b0110);
    drv(4'b0001, 4'b1011);
    idle();
    apb(1'b1, ADDR_CTRL, ctl(MODE_3L_DIR, 0, 0, 0));
    pin(4'b0001);
    pin(4'b0000);
    pin(4'b0100);
    drv(4'b1000, 4'b1011);
    idle();
    $display("test mode 3 done");
    results();
  end
endmodule : tb_top
`default_nettype wire
